/* File: dcl_pkg.sv */
// dcl_pkg: constants for the dc-balanced serial link block
// assumes 200 MHz core clock; link clock arrives as a sampled pin input
package dcl_pkg;
   localparam int LANES = 8;
   localparam int PAY_W = 6;
   localparam int SYM_W = 7;
   localparam int WORD_W = 48;
   localparam logic signed [4:0] RD_MAX = 5'sd7;
   localparam logic signed [4:0] RD_MIN = -5'sd6;
   localparam logic signed [4:0] RD_RESET = 5'sd0;
   localparam logic [6:0] CLK_PAT_NORM = 7'h78;   // 1111000
   localparam logic [6:0] CLK_PAT_TRAIN = 7'h7C;  // 1111100
   localparam logic [6:0] DATA_PAT_TRAIN = 7'h78; // 1111000
   localparam logic [2:0] TRAIN_MIN_CYC = 3'h4;
   localparam logic signed [2:0] STROBE_MAX = 3'sd3; // +1 bit in thirds
   localparam logic signed [2:0] STROBE_MIN = -3'sd3;
   localparam logic [3:0] AXI_OKAY = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_TXLO = 8'h08;
   localparam logic [7:0] REG_TXHI = 8'h0C;
   localparam logic [7:0] REG_RXLO = 8'h10;
   localparam logic [7:0] REG_RXHI = 8'h14;
   localparam logic [7:0] REG_RDISP = 8'h18;
   localparam int CTRL_BAL = 0;
   localparam int CTRL_TRN = 1;
   localparam int CTRL_DSK = 2;
   typedef enum logic [1:0] {
      DCL_RX_FIXED = 2'b00,
      DCL_RX_TRAIN = 2'b01,
      DCL_RX_LOCKED = 2'b10
   } dcl_rx_state_t;
endpackage

/* File: dcl_link.sv */
// dcl_link: lane coding, training pattern and receiver strobe alignment
// assumes axi4-lite master on core_clk; link clock is a pin sampled here
//
// Summary of operation
// R1: word spread over eight lanes plus clock
// R2: balance bit added per lane per cycle
// R3: disparity is ones minus zeros
// R4: running disparity may start anywhere -6..+7
// R5: add disparity minus one, or one minus disparity
// R6: running disparity saturates at +7 and -6
// R7: balance bit 0 plain, 1 inverted
// R8: both positive: send inverted
// R9: positive running, word non-positive: send plain
// R10: negative running, word positive: send plain
// R11: negative running, word non-positive: send inverted
// R12: running zero: always send inverted
// R13: seven bits per lane, per-lane accumulator
// R14: balancing only while balance select high
// R15: deskew only allowed in balanced mode
// R16: deskew corrects one bit of skew
// R17: training request low four cycles minimum
// R18: controller retrains after lock, power, cable
// R19: outputs low during deskew, clock keeps toggling
// R20: deskew off: fixed strobe, request held high
// R21: normal clock lane pattern 1111000
// R22: training clock lane pattern 1111100
// R23: training data pattern 1111000 on all lanes
// R24: per-lane strobe steps third-bit, range one bit
// R25: deskew at 80 MHz or less, train first
`timescale 1ns/1ps
`default_nettype none
module dcl_link (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic link_clk,
   input wire logic [3:0] s_axi_awaddr_unused,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic [55:0] serial_data_lane,
   output logic [6:0] clock_lane,
   output logic [47:0] rx_data,
   output logic rx_deskew_active
);
   // disparity of a 6-bit word: ones minus zeros
   function automatic logic signed [4:0] word_disp(input logic [5:0] w);
      logic signed [4:0] n;
      n = 5'sd0;
      for (int i = 0; i < 6; i++) begin
         n = n + {4'h0, w[i]};
      end
      word_disp = 5'(2 * n - 5'sd6); // see R3
   endfunction

   function automatic logic signed [4:0] sat_rd(input logic signed [5:0] v);
      if (v > 6'(dcl_pkg::RD_MAX)) begin
         sat_rd = dcl_pkg::RD_MAX; // see R6
      end else if (v < 6'(dcl_pkg::RD_MIN)) begin
         sat_rd = dcl_pkg::RD_MIN; // see R6
      end else begin
         sat_rd = 5'(v);
      end
   endfunction

   // link clock pin sampled, change taken when stages 2 and 3 agree
   logic lc_s1, lc_s2, lc_s3, lc_level, lc_prev;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lc_s1 <= 1'b0;
         lc_s2 <= 1'b0;
         lc_s3 <= 1'b0;
         lc_level <= 1'b0;
         lc_prev <= 1'b0;
      end else if (clk_en) begin
         lc_s1 <= link_clk;
         lc_s2 <= lc_s1;
         lc_s3 <= lc_s2;
         if (lc_s2 == lc_s3) begin
            lc_level <= lc_s3;
         end
         lc_prev <= lc_level;
      end
   end
   wire link_tick = lc_level & ~lc_prev;

   // control register
   logic balance_select, training_request_n, deskew_enable;
   logic [47:0] tx_word;
   logic signed [4:0] rdisp [dcl_pkg::LANES];

   // axi4-lite write path: address and data taken in either order
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire wr_ctrl = aw_addr == dcl_pkg::REG_CTRL;
   wire wr_txlo = aw_addr == dcl_pkg::REG_TXLO;
   wire wr_txhi = aw_addr == dcl_pkg::REG_TXHI;
   wire wr_ok = wr_ctrl | wr_txlo | wr_txhi;
   // deskew refused unless balanced mode requested too
   wire next_dsk = w_data[dcl_pkg::CTRL_DSK] & w_data[dcl_pkg::CTRL_BAL]; // see R15

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dcl_pkg::RESP_OKAY;
         balance_select <= 1'b0;
         training_request_n <= 1'b1;
         deskew_enable <= 1'b0;
         tx_word <= 48'h0000_0000_0000;
      end else if (clk_en) begin
         s_axi_awready <= ~aw_held & ~s_axi_awready;
         s_axi_wready <= ~w_held & ~s_axi_wready;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? dcl_pkg::RESP_OKAY : dcl_pkg::RESP_SLVERR;
            if (wr_ctrl & w_strb[0]) begin
               balance_select <= w_data[dcl_pkg::CTRL_BAL]; // see R14
               training_request_n <= w_data[dcl_pkg::CTRL_TRN];
               deskew_enable <= next_dsk; // see R15
            end
            if (wr_txlo) begin
               tx_word[31:0] <= w_data;
            end
            if (wr_txhi) begin
               tx_word[47:32] <= w_data[15:0];
            end
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // encoder per lane
   logic [dcl_pkg::LANES-1:0] invert;
   logic [55:0] next_lanes;
   logic signed [4:0] next_rd [dcl_pkg::LANES];
   genvar g;
   generate
      for (g = 0; g < dcl_pkg::LANES; g++) begin : g_lane
         wire [5:0] pay = tx_word[g*6 +: 6]; // see R1
         wire signed [4:0] wd = word_disp(pay);
         wire rd_pos = rdisp[g] > 5'sd0;
         wire rd_zero = rdisp[g] == 5'sd0;
         wire wd_pos = wd > 5'sd0;
         // zero running disparity always inverts
         assign invert[g] = rd_zero | (rd_pos ? wd_pos : ~wd_pos); // see R8 R9 R10 R11 R12
         wire signed [4:0] mod_d = invert[g] ? 5'(5'sd1 - wd) : 5'(wd - 5'sd1); // see R5
         assign next_rd[g] = sat_rd(6'(rdisp[g]) + 6'(mod_d)); // see R6
         wire [5:0] enc = invert[g] ? ~pay : pay;
         // balance bit first, then six payload bits
         assign next_lanes[g*7 +: 7] = ~training_request_n ? dcl_pkg::DATA_PAT_TRAIN : // see R23
            balance_select ? {invert[g], enc} : {1'b0, pay}; // see R2 R7 R13 R14
      end
   endgenerate

   // training request low-time counter, held so the receiver sees four cycles
   logic [2:0] trn_cnt;
   wire trn_done = trn_cnt >= dcl_pkg::TRAIN_MIN_CYC; // see R17
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         serial_data_lane <= 56'h00_0000_0000_0000;
         clock_lane <= dcl_pkg::CLK_PAT_NORM;
         trn_cnt <= 3'h0;
         for (int i = 0; i < dcl_pkg::LANES; i++) begin
            rdisp[i] <= dcl_pkg::RD_RESET; // see R4
         end
      end else if (clk_en & link_tick) begin
         serial_data_lane <= next_lanes;
         clock_lane <= training_request_n ? dcl_pkg::CLK_PAT_NORM : dcl_pkg::CLK_PAT_TRAIN; // see R21 R22
         if (training_request_n) begin
            trn_cnt <= 3'h0;
         end else if (!trn_done) begin
            trn_cnt <= trn_cnt + 3'h1;
         end
         if (balance_select & training_request_n) begin
            for (int i = 0; i < dcl_pkg::LANES; i++) begin
               rdisp[i] <= next_rd[i]; // see R5 R13
            end
         end
      end
   end

   // receiver side: loop back, per-lane strobe trained on the pattern
   dcl_pkg::dcl_rx_state_t rx_state, next_rx_state;
   logic signed [2:0] strobe [dcl_pkg::LANES];
   logic [dcl_pkg::LANES-1:0] lane_match;
   generate
      for (g = 0; g < dcl_pkg::LANES; g++) begin : g_rx
         assign lane_match[g] = serial_data_lane[g*7 +: 7] == dcl_pkg::DATA_PAT_TRAIN;
      end
   endgenerate
   wire training_seen = clock_lane == dcl_pkg::CLK_PAT_TRAIN;

   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         dcl_pkg::DCL_RX_FIXED: begin
            if (deskew_enable) begin
               next_rx_state = dcl_pkg::DCL_RX_TRAIN;
            end
         end
         dcl_pkg::DCL_RX_TRAIN: begin
            if (!deskew_enable) begin
               next_rx_state = dcl_pkg::DCL_RX_FIXED;
            end else if (trn_done & training_seen) begin
               next_rx_state = dcl_pkg::DCL_RX_LOCKED; // see R25
            end
         end
         dcl_pkg::DCL_RX_LOCKED: begin
            if (!deskew_enable) begin
               next_rx_state = dcl_pkg::DCL_RX_FIXED; // see R20
            end else if (training_seen & ~trn_done) begin
               // only a fresh request restarts training; a long one stays locked
               next_rx_state = dcl_pkg::DCL_RX_TRAIN; // see R18
            end
         end
         default: next_rx_state = dcl_pkg::DCL_RX_FIXED;
      endcase
   end
   wire in_deskew = next_rx_state == dcl_pkg::DCL_RX_TRAIN;

   // decode received lanes, undo inversion when balanced
   logic [47:0] next_rx;
   generate
      for (g = 0; g < dcl_pkg::LANES; g++) begin : g_dec
         wire [6:0] sym = serial_data_lane[g*7 +: 7];
         assign next_rx[g*6 +: 6] = (balance_select & sym[6]) ? ~sym[5:0] : sym[5:0];
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rx_state <= dcl_pkg::DCL_RX_FIXED;
         rx_data <= 48'h0000_0000_0000;
         rx_deskew_active <= 1'b0;
         for (int i = 0; i < dcl_pkg::LANES; i++) begin
            strobe[i] <= 3'sd0;
         end
      end else if (clk_en) begin
         rx_state <= next_rx_state;
         rx_deskew_active <= in_deskew;
         rx_data <= in_deskew ? 48'h0000_0000_0000 : next_rx; // see R19
         for (int i = 0; i < dcl_pkg::LANES; i++) begin
            if (!deskew_enable) begin
               strobe[i] <= 3'sd0; // see R20
            end else if (in_deskew & link_tick & ~lane_match[i] & (strobe[i] < dcl_pkg::STROBE_MAX)) begin
               // one third of a bit per step, clamped at one bit
               strobe[i] <= 3'(strobe[i] + 3'sd1); // see R16 R24
            end
         end
      end
   end

   // axi4-lite read path
   wire [31:0] stat_word = {24'h00_0000, 3'h0, trn_done, rx_deskew_active, 1'b0, rx_state};
   wire [31:0] rd_mux =
      s_axi_araddr == dcl_pkg::REG_CTRL ? {29'h0, deskew_enable, training_request_n, balance_select} :
      s_axi_araddr == dcl_pkg::REG_STAT ? stat_word :
      s_axi_araddr == dcl_pkg::REG_TXLO ? tx_word[31:0] :
      s_axi_araddr == dcl_pkg::REG_TXHI ? {16'h0000, tx_word[47:32]} :
      s_axi_araddr == dcl_pkg::REG_RXLO ? rx_data[31:0] :
      s_axi_araddr == dcl_pkg::REG_RXHI ? {16'h0000, rx_data[47:32]} :
      s_axi_araddr == dcl_pkg::REG_RDISP ? {27'h0, rdisp[0]} : 32'h0000_0000;
   wire rd_ok = s_axi_araddr <= dcl_pkg::REG_RDISP && s_axi_araddr[1:0] == 2'b00;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= dcl_pkg::RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= 1'b0;
         if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? dcl_pkg::RESP_OKAY : dcl_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   a_rd_saturate: assert property (@(posedge core_clk) disable iff (!rstn) // see R6
      rdisp[0] <= dcl_pkg::RD_MAX && rdisp[0] >= dcl_pkg::RD_MIN) else $error("disparity out of range");
   a_zero_inverts: assert property (@(posedge core_clk) disable iff (!rstn) // see R12
      clk_en && link_tick && balance_select && training_request_n && rdisp[0] == 5'sd0
      |=> serial_data_lane[6]) else $error("zero disparity not inverted");
   a_plain_mode: assert property (@(posedge core_clk) disable iff (!rstn) // see R14
      clk_en && link_tick && !balance_select && training_request_n |=> serial_data_lane[6] == 1'b0)
      else $error("balance bit in plain mode");
   a_train_clock: assert property (@(posedge core_clk) disable iff (!rstn) // see R22
      clk_en && link_tick && !training_request_n |=> clock_lane == dcl_pkg::CLK_PAT_TRAIN)
      else $error("wrong training clock pattern");
   a_norm_clock: assert property (@(posedge core_clk) disable iff (!rstn) // see R21
      clk_en && link_tick && training_request_n |=> clock_lane == dcl_pkg::CLK_PAT_NORM)
      else $error("wrong normal clock pattern");
   a_train_data: assert property (@(posedge core_clk) disable iff (!rstn) // see R23
      clk_en && link_tick && !training_request_n |=> serial_data_lane[6:0] == dcl_pkg::DATA_PAT_TRAIN)
      else $error("wrong training data pattern");
   a_deskew_low: assert property (@(posedge core_clk) disable iff (!rstn) // see R19
      rx_deskew_active |-> rx_data == 48'h0000_0000_0000) else $error("data not low in deskew");
   a_deskew_bal: assert property (@(posedge core_clk) disable iff (!rstn) // see R15
      deskew_enable |-> balance_select) else $error("deskew without balance");
   a_strobe_range: assert property (@(posedge core_clk) disable iff (!rstn) // see R24
      strobe[0] <= dcl_pkg::STROBE_MAX && strobe[0] >= dcl_pkg::STROBE_MIN)
      else $error("strobe out of range");

   // balanced normal tick: the step that moves every running disparity
   sequence s_bal_tick;
      clk_en && link_tick && balance_select && training_request_n;
   endsequence
   // four training ticks seen with deskew on and the receiver past fixed
   sequence s_trained;
      clk_en && deskew_enable && trn_done && training_seen && rx_state != dcl_pkg::DCL_RX_FIXED;
   endsequence
   // word sign taken from a ones count, not from the encoder's own function
   a_both_pos: assert property (@(posedge core_clk) disable iff (!rstn) // see R8
      s_bal_tick ##0 (rdisp[0] > 5'sd0 && $countones(tx_word[5:0]) > 3) |=> serial_data_lane[6])
      else $error("positive pair not inverted");
   a_pos_plain: assert property (@(posedge core_clk) disable iff (!rstn) // see R9
      s_bal_tick ##0 (rdisp[0] > 5'sd0 && $countones(tx_word[5:0]) <= 3) |=> !serial_data_lane[6])
      else $error("positive running word inverted");
   a_neg_plain: assert property (@(posedge core_clk) disable iff (!rstn) // see R10
      s_bal_tick ##0 (rdisp[0] < 5'sd0 && $countones(tx_word[5:0]) > 3) |=> !serial_data_lane[6])
      else $error("negative running positive word inverted");
   a_neg_invert: assert property (@(posedge core_clk) disable iff (!rstn) // see R11
      s_bal_tick ##0 (rdisp[0] < 5'sd0 && $countones(tx_word[5:0]) <= 3) |=> serial_data_lane[6])
      else $error("negative pair not inverted");
   a_lock_holds: assert property (@(posedge core_clk) disable iff (!rstn) // see R17
      s_trained |=> rx_state == dcl_pkg::DCL_RX_LOCKED)
      else $error("receiver not locked after training");
   a_fixed_strobe: assert property (@(posedge core_clk) disable iff (!rstn) // see R20
      clk_en && !deskew_enable |=> strobe[0] == 3'sd0)
      else $error("strobe moved with deskew off");
endmodule
`default_nettype wire

/* File: dcl_far_rx.sv */
// dcl_far_rx: far-end receiver model with the forwarded link clock source
// assumes lane g sits at bits g*7+6:g*7 with the balance flag in bit 6
`timescale 1ns/1ps
`default_nettype none
module dcl_far_rx (
   input wire logic [55:0] serial_data_lane,
   output logic link_clk,
   output logic [47:0] far_word
);
   logic [6:0] ln;
   // runs free; odd offset keeps its edges clear of core_clk edges
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #62.5 link_clk = ~link_clk;
   end
   always_comb begin
      far_word = 48'h0000_0000_0000;
      ln = 7'h00;
      for (int g = 0; g < 8; g++) begin
         ln = serial_data_lane[g*7 +: 7];
         far_word[g*6 +: 6] = ln[6] ? ~ln[5:0] : ln[5:0];
      end
   end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// tb_top: self-checking bench for dcl_link over axi4-lite and the lanes
// assumes writes finish inside half a link period, so words change between ticks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk, rstn, link_clk, chk_on, inv;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [55:0] serial_data_lane, exp_lanes;
   logic [6:0] clock_lane;
   logic [47:0] rx_data, far_word, m_word;
   logic rx_deskew_active;
   logic [2:0] m_ctrl;
   logic [5:0] p;
   logic [65:0] qe;
   logic [65:0] expq [$];
   int rdisp [8];
   int dsp, nxt, miscompares, comparisons;

   dcl_link uut (.core_clk(core_clk), .rstn(rstn), .clk_en(1'b1), .link_clk(link_clk),
      .s_axi_awaddr_unused(4'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .serial_data_lane(serial_data_lane),
      .clock_lane(clock_lane), .rx_data(rx_data), .rx_deskew_active(rx_deskew_active));
   dcl_far_rx far (.serial_data_lane(serial_data_lane), .link_clk(link_clk), .far_word(far_word));

   always #2.5 core_clk = ~core_clk;

   task automatic check(input logic [55:0] seen, input logic [55:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      expq.push_back({32'h0000_0000, r, 32'h0000_0000});
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rdreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d, input logic [1:0] r);
      expq.push_back({m, r, d & m});
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      arvalid <= 1'b0;
      rready <= 1'b0;
   endtask

   // changes land in the gap after a link falling edge, well before the next tick
   task automatic send_word(input logic [47:0] w);
      @(negedge link_clk);
      wr(dcl_pkg::REG_TXLO, w[31:0], dcl_pkg::RESP_OKAY);
      wr(dcl_pkg::REG_TXHI, {16'h0000, w[47:32]}, dcl_pkg::RESP_OKAY);
      m_word = w;
   endtask

   task automatic set_ctrl(input logic [2:0] c);
      @(negedge link_clk);
      wr(dcl_pkg::REG_CTRL, 32'(c), dcl_pkg::RESP_OKAY);
      m_ctrl = c;
      chk_on = 1'b1;
   endtask

   always @(posedge core_clk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         qe = expq.pop_front();
         if (bvalid && bready) check(bresp, qe[33:32]);
         else check({rresp, rdata & qe[65:34]}, qe[33:0]);
      end
   end

   // symbol of the last tick is settled by the falling edge
   always @(negedge link_clk) begin
      if (chk_on && !m_ctrl[1]) begin
         check(clock_lane, 7'h7C);
         check(serial_data_lane, {8{7'h78}});
         if (rx_deskew_active) check(rx_data, 48'h0000_0000_0000);
      end else if (chk_on) begin
         check(clock_lane, 7'h78);
         if (!rx_deskew_active) check(rx_data, m_word);
         check(far_word, m_word);
         for (int g = 0; g < 8; g++) begin
            p = m_word[g*6 +: 6];
            dsp = 2 * $countones(p) - 6;
            inv = m_ctrl[0] && (rdisp[g] == 0 || ((rdisp[g] > 0) == (dsp > 0)));
            exp_lanes[g*7 +: 7] = {inv, inv ? ~p : p};
            if (m_ctrl[0]) begin
               nxt = rdisp[g] + (inv ? 1 - dsp : dsp - 1);
               rdisp[g] = nxt > 7 ? 7 : (nxt < -6 ? -6 : nxt);
            end
         end
         check(serial_data_lane, exp_lanes);
      end
   end

   // whole run is some 50 link periods; this is ample margin
   initial begin
      #200000;
      miscompares++;
      summarize();
   end

   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      chk_on = 1'b0;
      m_ctrl = 3'h0;
      m_word = 48'h0000_0000_0000;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      void'($urandom(92));
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      rdreg(dcl_pkg::REG_CTRL, 32'h0000_0007, 32'h0000_0002, dcl_pkg::RESP_OKAY);
      rdreg(dcl_pkg::REG_RDISP, 32'h0000_001F, 32'h0000_0000, dcl_pkg::RESP_OKAY);
      rdreg(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, dcl_pkg::RESP_SLVERR);
      wr(8'h40, 32'hDEAD_BEEF, dcl_pkg::RESP_SLVERR);
      wr(dcl_pkg::REG_CTRL, 32'h0000_0006, dcl_pkg::RESP_OKAY);
      rdreg(dcl_pkg::REG_CTRL, 32'h0000_0007, 32'h0000_0002, dcl_pkg::RESP_OKAY);
      $display("test registers done");
      set_ctrl(3'h2);
      repeat (6) send_word(48'({$urandom(), $urandom()}));
      $display("test plain mode done");
      set_ctrl(3'h3);
      repeat (24) send_word(48'({$urandom(), $urandom()}));
      send_word(48'h0000_0000_0000);
      send_word(48'h0000_0000_0000);
      send_word(48'hFFFF_FFFF_FFFF);
      @(negedge link_clk);
      @(posedge core_clk);
      rdreg(dcl_pkg::REG_RDISP, 32'h0000_001F, 32'(5'(rdisp[0])), dcl_pkg::RESP_OKAY);
      $display("test balanced mode done");
      set_ctrl(3'h5);
      @(posedge core_clk);
      check({rx_deskew_active, rx_data}, {1'b1, 48'h0000_0000_0000});
      repeat (6) @(negedge link_clk);
      @(posedge core_clk);
      rdreg(dcl_pkg::REG_STAT, 32'h0000_001B, 32'h0000_0012, dcl_pkg::RESP_OKAY);
      set_ctrl(3'h3);
      repeat (4) send_word(48'({$urandom(), $urandom()}));
      $display("test training done");
      summarize();
   end
endmodule
`default_nettype wire
